/* File: logic/pcwrc_top.sv */
// Configuration registers, serial register slave, window control and reseed gating.
`timescale 1ns/100ps
`default_nettype none

module pcwrc_top #(
	parameter logic [6:0]  DEV_ADDR            = pcwrc_pkg::DEV_ADDR_DEFAULT,
	parameter int unsigned PWM_PERIOD_CYCLES   = pcwrc_pkg::PWM_PERIOD_CYCLES,
	parameter int unsigned TIMEOUT_UNIT_CYCLES = pcwrc_pkg::TIMEOUT_UNIT_CYCLES,
	parameter int unsigned NCH                 = pcwrc_pkg::NUM_CHANNELS
) (
	input  wire logic           clk_sys_i,
	input  wire logic           rst_i,
	input  wire logic           ce_i,
	input  wire logic           scl_i,
	input  wire logic           sda_i,
	output logic                sda_o,
	output logic                sda_oe_o,
	input  wire logic           comm_request_i,
	output logic                comm_window_open_o,
	output logic                pulse_output_pin_o,
	output logic                pulse_output_pin_oe_o,
	output logic                inductive_transmit_pin_en_o,
	output logic                inductive_sense_en_o,
	input  wire logic [NCH-1:0] ui_halt_reseed_i,
	input  wire logic [NCH-1:0] quick_release_reseed_i,
	input  wire logic [NCH-1:0] other_reseed_i,
	output logic      [NCH-1:0] reseed_o
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] power_mode_r;
	logic [7:0] pwm_duty_value_r;
	logic [7:0] comm_window_timeout_r;
	logic [7:0] serial_link_settings_r;
	logic [7:0] channel_reseed_enables_r;

	pcwrc_pkg::pcwrc_cfg_t cfg;

	assign cfg.pwm_en    = power_mode_r[pcwrc_pkg::BIT_PWM_ENABLE];
	assign cfg.duty      = pwm_duty_value_r;
	assign cfg.timeout   = comm_window_timeout_r;
	assign cfg.stop_hold = serial_link_settings_r[pcwrc_pkg::BIT_STOP_HOLD];
	assign cfg.reseed_en = channel_reseed_enables_r[NCH-1:0];

	// ****************************************************************
	// Bus condition detection
	// ****************************************************************
	logic scl_q_r;
	logic sda_q_r;

	// Every sampled level counts; a one-cycle pulse is a real edge.
	wire logic scl_rise  = scl_i & ~scl_q_r;
	wire logic scl_fall  = ~scl_i & scl_q_r;
	wire logic bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
	wire logic bus_stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else if (ce_i) begin
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
		end
	end

	// ****************************************************************
	// Serial register slave
	// ****************************************************************
	pcwrc_pkg::pcwrc_state_t state_r;
	pcwrc_pkg::pcwrc_state_t state_nxt;
	logic [3:0]              bitcnt_r;
	logic [6:0]              shift_r;
	logic [7:0]              ptr_r;
	logic [7:0]              ptr_nxt;
	logic [7:0]              tx_r;
	logic [7:0]              tx_nxt;
	logic                    ack_r;
	logic                    ack_nxt;
	logic                    sda_oe_r;
	logic                    sda_r;
	logic                    wr_en;

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == pcwrc_pkg::OFS_POWER_MODE) begin
			d = power_mode_r;
		end else if (a == pcwrc_pkg::OFS_PWM_DUTY) begin
			d = pwm_duty_value_r;
		end else if (a == pcwrc_pkg::OFS_WINDOW_TIMEOUT) begin
			d = comm_window_timeout_r;
		end else if (a == pcwrc_pkg::OFS_LINK_SETTINGS) begin
			d = serial_link_settings_r;
		end else if (a == pcwrc_pkg::OFS_RESEED_ENABLES) begin
			d = channel_reseed_enables_r;
		end
		return d;
	endfunction : reg_read

	wire logic [7:0] rx_byte   = {shift_r, sda_i};
	wire logic       byte_done = scl_rise & (bitcnt_r == 4'h7);
	wire logic       ack_bit   = scl_rise & (bitcnt_r == pcwrc_pkg::BITS_PER_BYTE);
	wire logic       addr_hit  = (rx_byte[7:1] == DEV_ADDR);
	wire logic [7:0] ptr_inc   = 8'(ptr_r + 8'h01);
	wire logic       master_rd = (state_r == pcwrc_pkg::PCWRC_RD) & ~ack_r;

	assign wr_en = byte_done & (state_r == pcwrc_pkg::PCWRC_WR);

	always_comb begin
		state_nxt = state_r;
		ptr_nxt   = ptr_r;
		tx_nxt    = tx_r;
		ack_nxt   = ack_r;
		if (byte_done) begin
			ack_nxt = 1'b0;
			case (state_r)
				pcwrc_pkg::PCWRC_ADDR: begin
					ack_nxt   = addr_hit;
					tx_nxt    = reg_read(ptr_r);
					state_nxt = !addr_hit ? pcwrc_pkg::PCWRC_IDLE :
						rx_byte[0] ? pcwrc_pkg::PCWRC_RD : pcwrc_pkg::PCWRC_PTR;
				end
				pcwrc_pkg::PCWRC_PTR: begin
					ack_nxt   = 1'b1;
					ptr_nxt   = rx_byte;
					state_nxt = pcwrc_pkg::PCWRC_WR;
				end
				pcwrc_pkg::PCWRC_WR: begin
					ack_nxt = 1'b1;
					ptr_nxt = ptr_inc;
				end
				default: begin
					ack_nxt = 1'b0;
				end
			endcase
		end else if (ack_bit) begin
			ack_nxt = 1'b0;
			if (master_rd & sda_i) begin
				state_nxt = pcwrc_pkg::PCWRC_IDLE;
			end else if (master_rd) begin
				ptr_nxt = ptr_inc;
				tx_nxt  = reg_read(ptr_inc);
			end
		end else if (scl_fall & (state_r == pcwrc_pkg::PCWRC_RD) &
				(bitcnt_r != pcwrc_pkg::BITS_PER_BYTE)) begin
			tx_nxt = {tx_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r  <= pcwrc_pkg::PCWRC_IDLE;
			bitcnt_r <= 4'h0;
			shift_r  <= 7'h00;
			ptr_r    <= 8'h00;
			tx_r     <= 8'h00;
			ack_r    <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_r    <= 1'b0;
		end else if (ce_i) begin
			sda_r <= 1'b0;
			if (bus_start) begin
				state_r  <= pcwrc_pkg::PCWRC_ADDR;
				bitcnt_r <= 4'h0;
				ack_r    <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (bus_stop) begin
				state_r  <= pcwrc_pkg::PCWRC_IDLE;
				ack_r    <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (state_r != pcwrc_pkg::PCWRC_IDLE) begin
				state_r <= state_nxt;
				ptr_r   <= ptr_nxt;
				tx_r    <= tx_nxt;
				ack_r   <= ack_nxt;
				if (scl_rise) begin
					shift_r  <= rx_byte[6:0];
					bitcnt_r <= ack_bit ? 4'h0 : 4'(bitcnt_r + 4'h1);
				end
				if (scl_fall) begin
					sda_oe_r <= (bitcnt_r == pcwrc_pkg::BITS_PER_BYTE) ? ack_r :
						(state_r == pcwrc_pkg::PCWRC_RD) & ~tx_r[7];
				end
			end else begin
				sda_oe_r <= 1'b0;
			end
		end
	end

	assign sda_o    = sda_r;
	assign sda_oe_o = sda_oe_r;

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			power_mode_r             <= pcwrc_pkg::RST_POWER_MODE;
			pwm_duty_value_r         <= pcwrc_pkg::RST_PWM_DUTY;
			comm_window_timeout_r    <= pcwrc_pkg::RST_WINDOW_TIMEOUT;
			serial_link_settings_r   <= pcwrc_pkg::RST_LINK_SETTINGS;
			channel_reseed_enables_r <= pcwrc_pkg::RST_RESEED_ENABLES;
		end else if (ce_i & wr_en) begin
			if (ptr_r == pcwrc_pkg::OFS_POWER_MODE) begin
				power_mode_r <= rx_byte;
			end else if (ptr_r == pcwrc_pkg::OFS_PWM_DUTY) begin
				pwm_duty_value_r <= rx_byte;
			end else if (ptr_r == pcwrc_pkg::OFS_WINDOW_TIMEOUT) begin
				comm_window_timeout_r <= rx_byte;
			end else if (ptr_r == pcwrc_pkg::OFS_LINK_SETTINGS) begin
				// Bit 0 is stored as written; the host keeps it set.
				serial_link_settings_r <= rx_byte & pcwrc_pkg::MASK_LINK_SETTINGS;
			end else if (ptr_r == pcwrc_pkg::OFS_RESEED_ENABLES) begin
				channel_reseed_enables_r <= rx_byte & pcwrc_pkg::MASK_RESEED_ENABLES;
			end
		end
	end

	// ****************************************************************
	// Communication window
	// ****************************************************************
	logic        window_r;
	logic        armed_r;
	logic [31:0] unit_cnt_r;
	logic [7:0]  units_r;

	wire logic unit_tick = (unit_cnt_r == 32'(TIMEOUT_UNIT_CYCLES - 1));
	wire logic expired   = armed_r & (units_r == cfg.timeout);
	wire logic close_now = (bus_stop & ~cfg.stop_hold) | (expired & cfg.stop_hold);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			window_r   <= 1'b0;
			armed_r    <= 1'b0;
			unit_cnt_r <= 32'h00000000;
			units_r    <= 8'h00;
		end else if (ce_i) begin
			// A new request wins over a close in the same cycle.
			window_r <= comm_request_i | (window_r & ~close_now);
			if (comm_request_i | bus_stop) begin
				armed_r    <= 1'b1;
				unit_cnt_r <= 32'h00000000;
				units_r    <= 8'h00;
			end else if (bus_start | ~window_r | expired) begin
				armed_r <= 1'b0;
			end else if (armed_r) begin
				unit_cnt_r <= unit_tick ? 32'h00000000 : 32'(unit_cnt_r + 32'h1);
				units_r    <= unit_tick ? 8'(units_r + 8'h01) : units_r;
			end
		end
	end

	assign comm_window_open_o = window_r;

	// ****************************************************************
	// PWM pin and inductive function
	// ****************************************************************
	logic pin_oe_r;
	logic ltx_en_r;
	logic sense_en_r;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_oe_r   <= 1'b0;
			ltx_en_r   <= 1'b1;
			sense_en_r <= 1'b1;
		end else if (ce_i) begin
			pin_oe_r   <= cfg.pwm_en;
			ltx_en_r   <= ~cfg.pwm_en;
			sense_en_r <= ~cfg.pwm_en;
		end
	end

	pcwrc_pwm #(
		.PERIOD_CYCLES (PWM_PERIOD_CYCLES)
	) u_pwm (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.en_i      (cfg.pwm_en),
		.duty_i    (cfg.duty),
		.pwm_o     (pulse_output_pin_o)
	);

	assign pulse_output_pin_oe_o       = pin_oe_r;
	assign inductive_transmit_pin_en_o = ltx_en_r;
	assign inductive_sense_en_o        = sense_en_r;

	// ****************************************************************
	// Reseed gating
	// ****************************************************************
	logic [NCH-1:0] reseed_r;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_reseed
			always_ff @(posedge clk_sys_i) begin
				if (rst_i) begin
					reseed_r[ch] <= 1'b0;
				end else if (ce_i) begin
					reseed_r[ch] <= other_reseed_i[ch] | (cfg.reseed_en[ch] &
						(ui_halt_reseed_i[ch] | quick_release_reseed_i[ch]));
				end
			end
		end
	endgenerate

	assign reseed_o = reseed_r;

endmodule : pcwrc_top

`default_nettype wire

/* File: logic/pcwrc_pkg.sv */
// Constants and types shared by the PWM, communication window and reseed configuration block.
package pcwrc_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_HZ              = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS       = 40;
	localparam int unsigned PWM_FREQ_HZ         = 1000;
	localparam int unsigned PWM_STEPS           = 256;
	localparam int unsigned PWM_PERIOD_CYCLES   = CLK_HZ / PWM_FREQ_HZ;
	localparam int unsigned TIMEOUT_UNIT_NS     = 320_000;
	localparam int unsigned TIMEOUT_UNIT_CYCLES = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_POWER_MODE      = 8'hD2;
	localparam logic [7:0] OFS_PWM_DUTY        = 8'hD8;
	localparam logic [7:0] OFS_WINDOW_TIMEOUT  = 8'hD9;
	localparam logic [7:0] OFS_LINK_SETTINGS   = 8'hDA;
	localparam logic [7:0] OFS_RESEED_ENABLES  = 8'hDB;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_POWER_MODE      = 8'h03;
	localparam logic [7:0] RST_PWM_DUTY        = 8'h00;
	localparam logic [7:0] RST_WINDOW_TIMEOUT  = 8'h20;
	localparam logic [7:0] RST_LINK_SETTINGS   = 8'h01;
	localparam logic [7:0] RST_RESEED_ENABLES  = 8'h07;

	// ****************************************************************
	// Field positions and masks
	// ****************************************************************
	localparam int unsigned BIT_PWM_ENABLE     = 7;
	localparam int unsigned BIT_STOP_HOLD      = 7;
	localparam int unsigned BIT_LINK_ALWAYS1   = 0;
	localparam int unsigned NUM_CHANNELS       = 3;
	localparam logic [7:0] MASK_LINK_SETTINGS  = 8'h81;
	localparam logic [7:0] MASK_RESEED_ENABLES = 8'h07;

	// ****************************************************************
	// Serial slave
	// ****************************************************************
	// Arbitrary neutral device address.
	localparam logic [6:0] DEV_ADDR_DEFAULT    = 7'h44;
	localparam logic [3:0] BITS_PER_BYTE       = 4'h8;

	typedef enum logic [2:0] {
		PCWRC_IDLE,
		PCWRC_ADDR,
		PCWRC_PTR,
		PCWRC_WR,
		PCWRC_RD
	} pcwrc_state_t;

	typedef struct packed {
		logic                    pwm_en;
		logic [7:0]              duty;
		logic [7:0]              timeout;
		logic                    stop_hold;
		logic [NUM_CHANNELS-1:0] reseed_en;
	} pcwrc_cfg_t;

endpackage : pcwrc_pkg

/* File: logic/pcwrc_pwm.sv */
// Fixed-period PWM generator with 256 duty steps and period-aligned duty updates.
`timescale 1ns/100ps
`default_nettype none

module pcwrc_pwm #(
	parameter int unsigned PERIOD_CYCLES = pcwrc_pkg::PWM_PERIOD_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       en_i,
	input  wire logic [7:0] duty_i,
	output logic            pwm_o
);

	localparam logic [23:0] PERIOD_W = 24'(PERIOD_CYCLES);
	localparam logic [23:0] LAST_W   = 24'(PERIOD_CYCLES - 1);
	localparam logic [23:0] STEPS_W  = 24'(pcwrc_pkg::PWM_STEPS);

	logic [23:0] cnt_r;
	logic [7:0]  duty_r;
	logic        pwm_r;

	wire logic        wrap     = (cnt_r == LAST_W);
	wire logic [23:0] phase    = 24'(cnt_r * STEPS_W);
	wire logic [23:0] high_lim = 24'(({16'h0000, duty_r} + 24'h000001) * PERIOD_W);
	wire logic        high_nxt = (phase < high_lim);

	// While enabled, a new duty value is taken only at a period boundary; while disabled it is loaded every cycle.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_r  <= 24'h000000;
			duty_r <= 8'h00;
			pwm_r  <= 1'b0;
		end else if (ce_i) begin
			if (!en_i) begin
				cnt_r  <= 24'h000000;
				duty_r <= duty_i;
				pwm_r  <= 1'b0;
			end else begin
				cnt_r  <= wrap ? 24'h000000 : 24'(cnt_r + 24'h000001);
				duty_r <= wrap ? duty_i : duty_r;
				pwm_r  <= high_nxt;
			end
		end
	end

	assign pwm_o = pwm_r;

endmodule : pcwrc_pwm

`default_nettype wire

/* File: verification/pcwrc_top_assertions.sv */
// Concurrent checks on the configuration block's pins.
`timescale 1ns/100ps
`default_nettype none
module pcwrc_top_assertions #(
	parameter int unsigned PWM_PERIOD_CYCLES = 512,
	parameter int unsigned NCH               = 3
) (
	input wire logic		clk_sys_i,
	input wire logic		rst_i,
	input wire logic		ce_i,
	input wire logic		comm_request_i,
	input wire logic		comm_window_open_o,
	input wire logic		pulse_output_pin_o,
	input wire logic		pulse_output_pin_oe_o,
	input wire logic		inductive_transmit_pin_en_o,
	input wire logic		inductive_sense_en_o,
	input wire logic [NCH-1:0]	ui_halt_reseed_i,
	input wire logic [NCH-1:0]	quick_release_reseed_i,
	input wire logic [NCH-1:0]	other_reseed_i,
	input wire logic [NCH-1:0]	reseed_o
);
	logic [15:0]	since_rise_r;
	logic		seen_r;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !pulse_output_pin_oe_o) begin
			since_rise_r <= 16'h0000;
			seen_r <= 1'b0;
		end else if ($rose(pulse_output_pin_o)) begin
			since_rise_r <= 16'h0000;
			seen_r <= 1'b1;
		end else if (ce_i) begin
			since_rise_r <= since_rise_r + 16'h0001;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_pwm_off;
		!pulse_output_pin_oe_o ##1 !pulse_output_pin_oe_o;
	endsequence
	sequence s_pwm_on;
		pulse_output_pin_oe_o [*2];
	endsequence
	property p_pin_quiet;
		s_pwm_off |-> !pulse_output_pin_o;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet)
		else $error("PWM pin active while disabled.");
	property p_ltx_taken;
		s_pwm_on |-> !inductive_transmit_pin_en_o;
	endproperty
	a_ltx_taken: assert property (p_ltx_taken)
		else $error("Transmit function kept while PWM runs.");
	property p_sense_taken;
		s_pwm_on |-> !inductive_sense_en_o;
	endproperty
	a_sense_taken: assert property (p_sense_taken)
		else $error("Inductive sensing kept while PWM runs.");
	property p_pins_free;
		s_pwm_off |-> inductive_transmit_pin_en_o && inductive_sense_en_o;
	endproperty
	a_pins_free: assert property (p_pins_free)
		else $error("Inductive function blocked without PWM.");
	property p_period;
		$rose(pulse_output_pin_o) && seen_r |->
			((since_rise_r + 16'h0001) % PWM_PERIOD_CYCLES) == 0;
	endproperty
	a_period: assert property (p_period)
		else $error("PWM rising edges off the fixed period.");
	property p_other_reseed;
		!$past(rst_i) && $past(ce_i) |->
			(reseed_o & $past(other_reseed_i)) == $past(other_reseed_i);
	endproperty
	a_other_reseed: assert property (p_other_reseed)
		else $error("Ungated reseed source was blocked.");
	property p_reseed_cause;
		!$past(rst_i) && $past(ce_i) |->
			(reseed_o & ~($past(other_reseed_i) | $past(ui_halt_reseed_i)
			| $past(quick_release_reseed_i))) == '0;
	endproperty
	a_reseed_cause: assert property (p_reseed_cause)
		else $error("Reseed issued without a request.");
	property p_window_req;
		comm_request_i |=> comm_window_open_o;
	endproperty
	a_window_req: assert property (p_window_req)
		else $error("Window did not open on request.");
endmodule : pcwrc_top_assertions
bind pcwrc_top pcwrc_top_assertions #(
	.PWM_PERIOD_CYCLES(PWM_PERIOD_CYCLES),
	.NCH(NCH)
) chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
	.comm_request_i(comm_request_i),
	.comm_window_open_o(comm_window_open_o), .pulse_output_pin_o(pulse_output_pin_o),
	.pulse_output_pin_oe_o(pulse_output_pin_oe_o),
	.inductive_transmit_pin_en_o(inductive_transmit_pin_en_o),
	.inductive_sense_en_o(inductive_sense_en_o), .ui_halt_reseed_i(ui_halt_reseed_i),
	.quick_release_reseed_i(quick_release_reseed_i), .other_reseed_i(other_reseed_i),
	.reseed_o(reseed_o));
`default_nettype wire

/* File: verification/pcwrc_host.sv */
// Serial host controller model that reads and writes the configuration registers.
`timescale 1ns/100ps
`default_nettype none
module pcwrc_host #(
	parameter logic [6:0] ADDR = pcwrc_pkg::DEV_ADDR_DEFAULT
) (
	input wire logic	clk_sys_i,
	input wire logic	sda_i,
	output logic		scl_o = 1'b1,
	output logic		sda_low_o = 1'b0,
	output logic		rd_valid_o = 1'b0,
	output logic [7:0]	rd_data_o = 8'h00
);
	logic	last_ack = 1'b0;
	logic	addr_ack = 1'b0;
	int	hold = 4;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	// Start (or repeated start) when is_stop is low, stop otherwise.
	task automatic cond(input logic is_stop);
		tick(1);
		sda_low_o <= is_stop;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_low_o <= !is_stop;
		tick(4);
		if (!is_stop) scl_o <= 1'b0;
	endtask : cond
	task automatic xbit(input logic b, output logic r);
		tick(1);
		sda_low_o <= !b;
		tick(3);
		scl_o <= 1'b1;
		tick(hold);
		r = sda_i;
		scl_o <= 1'b0;
	endtask : xbit
	task automatic xbyte(input logic [7:0] d, input logic nack, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r);
			q[i] = r;
		end
		xbit(nack, r);
		last_ack = !r;
	endtask : xbyte
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic [7:0] v;
		v = d;
		if (a == pcwrc_pkg::OFS_LINK_SETTINGS) v = (d & 8'h80) | 8'h01;
		cond(1'b0);
		xbyte({dev, 1'b0}, 1'b1, q);
		addr_ack = last_ack;
		xbyte(a, 1'b1, q);
		xbyte(v, 1'b1, q);
		cond(1'b1);
	endtask : write_reg
	// Reads n bytes in one burst; every byte but the last is acknowledged.
	task automatic read_reg(input logic [7:0] a, input int n);
		logic [7:0] q;
		cond(1'b0);
		xbyte({ADDR, 1'b0}, 1'b1, q);
		xbyte(a, 1'b1, q);
		cond(1'b0);
		xbyte({ADDR, 1'b1}, 1'b1, q);
		for (int i = 1; i <= n; i++) begin
			xbyte(8'hFF, (i == n), q);
			rd_data_o <= q;
			rd_valid_o <= 1'b1;
			tick(1);
			rd_valid_o <= 1'b0;
		end
		cond(1'b1);
	endtask : read_reg
endmodule : pcwrc_host
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the configuration block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int unsigned PER = 512;
	localparam int unsigned UNIT = 16;
	localparam int unsigned TV = 4;
	logic		clk_sys_i = 1'b0;
	logic		rst_i = 1'b1;
	logic		ce = 1'b1;
	logic		req = 1'b0;
	logic [2:0]	ui = 3'h0;
	logic [2:0]	qr = 3'h0;
	logic [2:0]	oth = 3'h0;
	logic [7:0]	v;
	logic [7:0]	e;
	logic [7:0]	exp_q[$];
	int		miscompares = 0;
	int		checks_done = 0;
	int		seed = 19076;
	int		hi;
	wire logic	scl, sda_low, rd_valid, sda_o, sda_oe, win, pin, pin_oe, inductive_transmit_pin, sense;
	wire logic [7:0] rd_data;
	wire logic [2:0] rsd;
	wire logic	sda = !(sda_low | sda_oe);
	always #20 clk_sys_i = !clk_sys_i;
	pcwrc_top #(.PWM_PERIOD_CYCLES(PER), .TIMEOUT_UNIT_CYCLES(UNIT)) pcwrc_top_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .comm_request_i(req), .comm_window_open_o(win),
		.pulse_output_pin_o(pin), .pulse_output_pin_oe_o(pin_oe),
		.inductive_transmit_pin_en_o(inductive_transmit_pin), .inductive_sense_en_o(sense),
		.ui_halt_reseed_i(ui), .quick_release_reseed_i(qr), .other_reseed_i(oth),
		.reseed_o(rsd));
	pcwrc_host pcwrc_host_i (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
		.sda_low_o(sda_low), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
	task automatic fail(input string m);
		miscompares++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : fail
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x, input string m);
		checks_done++;
		if (g !== x) fail($sformatf("%s got %h expected %h", m, g, x));
	endtask : cmp_byte
	task automatic cmp_bit(input logic g, input logic x, input string m);
		checks_done++;
		if (g !== x) fail(m);
	endtask : cmp_bit
	task automatic cmp_num(input int g, input int x, input string m);
		checks_done++;
		if (g != x) fail($sformatf("%s got %0d expected %0d", m, g, x));
	endtask : cmp_num
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		pcwrc_host_i.read_reg(a, 1);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		pcwrc_host_i.write_reg(pcwrc_pkg::DEV_ADDR_DEFAULT, a, d);
	endtask : wr
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tk
	task automatic count_high(output int n);
		n = 0;
		repeat (PER) begin
			@(posedge clk_sys_i);
			if (pin === 1'b1) n++;
		end
	endtask : count_high
	task automatic pulse_req;
		@(posedge clk_sys_i) req <= 1'b1;
		@(posedge clk_sys_i) req <= 1'b0;
		@(posedge clk_sys_i);
	endtask : pulse_req
	always @(posedge clk_sys_i) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) fail("unexpected read");
			else cmp_byte(rd_data, exp_q.pop_front(), "read");
		end
	end
	initial begin
		#(40 * 40000);
		fail("timeout");
		print_verdict();
	end
	initial begin
		tk(8);
		rst_i <= 1'b0;
		tk(4);
		cmp_bit(pin_oe, 1'b0, "pin enable after reset");
		cmp_bit(inductive_transmit_pin, 1'b1, "transmit after reset");
		rd(8'hD2, 8'h03);
		rd(8'hD8, 8'h00);
		rd(8'hD9, 8'h20);
		rd(8'hDA, 8'h01);
		rd(8'hDB, 8'h07);
		rd(8'hC0, 8'h00);
		$display("test reset values done");
		v = 8'($random(seed));
		wr(8'hD8, v);
		cmp_bit(pcwrc_host_i.addr_ack, 1'b1, "own address refused");
		pcwrc_host_i.write_reg(pcwrc_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 8'hD8, ~v);
		cmp_bit(pcwrc_host_i.addr_ack, 1'b0, "foreign address acked");
		rd(8'hD8, v);
		v = 8'($random(seed));
		wr(8'hD9, v);
		rd(8'hD9, v);
		v = 8'($random(seed));
		wr(8'hDB, v);
		rd(8'hDB, v & 8'h07);
		wr(8'hDA, 8'h80);
		rd(8'hDA, 8'h81);
		exp_q.push_back(8'h81);
		exp_q.push_back(v & 8'h07);
		pcwrc_host_i.read_reg(8'hDA, 2);
		wr(8'hC0, 8'h5A);
		rd(8'hC0, 8'h00);
		$display("test register access done");
		pcwrc_host_i.hold = 9;
		wr(8'hD2, 8'h83);
		for (int i = 0; i < 4; i++) begin
			e = (i == 0) ? 8'h00 : (i == 1) ? 8'($random(seed)) : 8'hFD + 8'(i);
			wr(8'hD8, e);
			tk(2 * PER);
			count_high(hi);
			cmp_num(hi, (int'(e) + 1) * PER / 256, "high time");
		end
		cmp_bit(pin_oe, 1'b1, "pin not taken");
		cmp_bit(inductive_transmit_pin, 1'b0, "transmit kept");
		cmp_bit(sense, 1'b0, "sensing kept");
		wr(8'hD2, 8'h03);
		tk(4);
		count_high(hi);
		cmp_num(hi, 0, "pulses while disabled");
		cmp_bit(inductive_transmit_pin, 1'b1, "transmit not returned");
		pcwrc_host_i.hold = 4;
		$display("test pwm done");
		wr(8'hDA, 8'h00);
		pulse_req();
		cmp_bit(win, 1'b1, "window not open");
		wr(8'hD9, 8'(TV));
		tk(2);
		cmp_bit(win, 1'b0, "stop did not close");
		wr(8'hDA, 8'h80);
		pulse_req();
		wr(8'hD9, 8'(TV));
		tk(TV * UNIT / 2);
		cmp_bit(win, 1'b1, "window closed early");
		wr(8'hD9, 8'(TV));
		cmp_bit(win, 1'b1, "stop closed held window");
		tk(TV * UNIT / 2);
		cmp_bit(win, 1'b1, "timeout too short");
		tk(TV * UNIT / 2 + 16);
		cmp_bit(win, 1'b0, "timeout missing");
		$display("test window done");
		for (int k = 0; k < 3; k++) begin
			e = (k == 0) ? 8'h00 : (k == 1) ? 8'h07 : 8'($random(seed));
			wr(8'hDB, e);
			repeat (10) begin
				@(posedge clk_sys_i);
				ui <= 3'($random(seed));
				qr <= 3'($random(seed));
				oth <= 3'($random(seed));
				@(posedge clk_sys_i);
				@(negedge clk_sys_i);
				cmp_byte({5'h00, rsd}, {5'h00, oth | (e[2:0] & (ui | qr))}, "reseed");
			end
		end
		v = {5'h00, oth | (e[2:0] & (ui | qr))};
		@(posedge clk_sys_i);
		ce <= 1'b0;
		oth <= ~oth;
		tk(3);
		cmp_byte({5'h00, rsd}, v, "reseed moved while frozen");
		ce <= 1'b1;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		cmp_byte({5'h00, rsd}, {5'h00, oth | (e[2:0] & (ui | qr))}, "reseed after freeze");
		$display("test reseed done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
